// ===== adc_mode_pkg.sv
// adc_mode_pkg: constants for the operating-mode control register block.
// assumes: shared by the mode control module and its bench only.
package adc_mode_pkg;

    // register map: one mode register written at 0x38..0x3f, read at 0x38 only
    localparam logic [7:0] MODE_REG_ADDR     = 8'h38; // the only read address
    localparam logic [4:0] MODE_REG_ADDR_HI  = 5'h07; // address bits 7..3
    localparam logic [7:0] MODE_REG_RESET    = 8'h00;

    // field positions
    localparam int OP_MODE_MSB    = 7;
    localparam int OP_MODE_LSB    = 5;
    localparam int CLK_OFF_BIT    = 4;
    localparam int CHAIN_READ_BIT = 3;
    localparam int CONT_READ_BIT  = 2;
    localparam int WIDE_DATA_BIT  = 1;
    localparam int CLAMP_BIT      = 0;

    // op_mode_field encodings
    localparam logic [2:0] OP_IDLE       = 3'h0;
    localparam logic [2:0] OP_CONT_CONV  = 3'h1;
    localparam logic [2:0] OP_SINGLE     = 3'h2;
    localparam logic [2:0] OP_STANDBY    = 3'h3;
    localparam logic [2:0] OP_SELF_ZERO  = 3'h4;
    localparam logic [2:0] OP_SELF_FULL  = 3'h5;
    localparam logic [2:0] OP_SYS_ZERO   = 3'h6;
    localparam logic [2:0] OP_SYS_FULL   = 3'h7;

    // channel data widths
    localparam int SAMPLE_WIDTH = 24;
    localparam int SHORT_WIDTH  = 16;

    // values after reset of sequencer outputs
    localparam logic READY_N_RESET = 1'b1;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONT,
        ST_SINGLE,
        ST_STANDBY,
        ST_CAL
    } seq_state_t;

endpackage : adc_mode_pkg

// ===== adc_mode_control.sv
// adc_mode_control: operating-mode register and mode sequencer of a
// multichannel sigma-delta converter.
// assumes: a serial front end on LINK_CLK_I presents decoded register
// strobes; the modulator/filter sits on CLK_SYS_I behind CONV_* ports.
//
// Summary of operation
// - Any mode write clears status, raises ready, aborts work, starts mode.
// - One 8-bit mode register answers writes at 0x38..0x3f, resets to 0x00.
// - Write captures address bits 1..0 as argument; host reads only at 0x38.
// - Bits: mode 7..5, clock off 4, chain 3, cont read 2, width 1, clamp 0.
// - A newly written mode takes over at once, no waiting for running work.
// - Mode codes: idle, continuous, single, standby, four calibration kinds.
// - Argument picks channel, or calibration time, according to the mode.
// - Clock-out off bit stops and floats the master clock output pin.
// - Crystal plus clock-out off halts conversions; link stays usable.
// - Chain bit set makes a status read continue with channel data.
// - Continuous read always returns status then data, whatever chain says.
// - Width bit selects 24-bit or 16-bit channel data.
// - Clamp bit forces out-of-range data to all zeros or all ones.
// - Single or calibration done: set ready, pin low, mode field idle.
// - Continuous: each result sets its ready bit, then next channel.
`timescale 1ns/100ps
module adc_mode_control
    import adc_mode_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
)(
    // system clock and reset
    input  wire logic                    CLK_SYS_I,
    input  wire logic                    RESETN_I,
    // register port from the serial front end, link clock domain
    input  wire logic                    LINK_CLK_I,
    input  wire logic                    LINK_WR_I,
    input  wire logic                    LINK_RD_I,
    input  wire logic [7:0]              LINK_ADDR_I,
    input  wire logic [7:0]              LINK_WDATA_I,
    output logic      [7:0]              LINK_RDATA_O,
    // master clock pins
    input  wire logic                    CRYSTAL_MODE_I,
    output logic                         MASTER_CLOCK_OUTPUT_PIN_O,
    output logic                         MASTER_CLOCK_OUTPUT_PIN_OE_O,
    // converter core
    input  wire logic [NUM_CHANNELS-1:0] CHANNEL_ENABLE_I,
    input  wire logic                    CONV_DONE_I,
    input  wire logic [SAMPLE_WIDTH-1:0] SAMPLE_I,
    input  wire logic                    OVER_RANGE_I,
    input  wire logic                    UNDER_RANGE_I,
    output logic                         CONV_START_O,
    output logic                         CONV_ABORT_O,
    output logic      [2:0]              CONV_OP_O,
    output logic      [$clog2(NUM_CHANNELS)-1:0] CONV_CHANNEL_O,
    output logic      [1:0]              CAL_TIME_SEL_O,
    output logic                         STANDBY_O,
    output logic                         CONVERSION_HALT_O,
    // results and status
    output logic      [SAMPLE_WIDTH-1:0] CHAN_DATA_O,
    output logic      [$clog2(NUM_CHANNELS)-1:0] CHAN_DATA_CH_O,
    output logic                         CHAN_DATA_VALID_O,
    output logic      [NUM_CHANNELS-1:0] ADC_STATUS_O,
    output logic                         READY_N_O,
    // read formatting for the serial front end
    output logic                         CHAIN_READ_O,
    output logic                         CONT_READ_O,
    output logic                         WIDE_DATA_O
);

    localparam int CH_W = $clog2(NUM_CHANNELS);

    // elaboration check: argument of two bits must name a channel
    if (NUM_CHANNELS < 4 || NUM_CHANNELS > 256)
        $error("NUM_CHANNELS must lie between 4 and 256");

    // ---------------- link domain ----------------
    logic [7:0] wr_data_hold;
    logic [1:0] wr_arg_hold;
    logic       wr_tgl;
    logic       mir_meta;
    logic       mir_sync;
    logic       mir_seen;
    logic [7:0] link_copy;

    // capture a mode write; any of the eight aliases is accepted
    always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            wr_data_hold <= MODE_REG_RESET;
            wr_arg_hold  <= 2'h0;
            wr_tgl       <= 1'b0;
        end
        else if (LINK_WR_I && LINK_ADDR_I[7:3] == MODE_REG_ADDR_HI)
        begin
            wr_data_hold <= LINK_WDATA_I;
            wr_arg_hold  <= LINK_ADDR_I[1:0];
            wr_tgl       <= ~wr_tgl;
        end
    end

    // receive the register mirror sent from the system domain
    logic [7:0] mirror_data_reg;
    logic       mirror_tgl_reg;
    always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            mir_meta  <= 1'b0;
            mir_sync  <= 1'b0;
            mir_seen  <= 1'b0;
            link_copy <= MODE_REG_RESET;
        end
        else
        begin
            mir_meta <= mirror_tgl_reg;
            mir_sync <= mir_meta;
            mir_seen <= mir_sync;
            if (mir_sync != mir_seen)
                link_copy <= mirror_data_reg;
        end
    end

    // read port: only the base address returns the register
    always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            LINK_RDATA_O <= 8'h00;
        else if (LINK_RD_I)
            LINK_RDATA_O <= (LINK_ADDR_I == MODE_REG_ADDR)
                            ? link_copy : 8'h00;
    end

    // ---------------- system domain ----------------
    logic       wr_meta;
    logic       wr_sync;
    logic       wr_seen;
    logic       wr_event;
    logic [7:0] mode_reg;
    logic [1:0] arg_reg;
    logic       xtal_meta;
    logic       xtal_sync;
    logic       run_ok;
    logic       op_finish;
    logic       ack_meta;
    logic       ack_sync;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic       start_pending_reg;
    logic [CH_W-1:0] channel_reg;
    logic [NUM_CHANNELS-1:0] status_reg;

    // synchronise the write toggle and the crystal strap
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            wr_meta   <= 1'b0;
            wr_sync   <= 1'b0;
            wr_seen   <= 1'b0;
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
        end
        else
        begin
            wr_meta   <= wr_tgl;
            wr_sync   <= wr_meta;
            wr_seen   <= wr_sync;
            xtal_meta <= CRYSTAL_MODE_I;
            xtal_sync <= xtal_meta;
        end
    end

    assign wr_event = wr_sync ^ wr_seen;
    // crystal clocking stops with the output pin; serial side keeps running
    assign run_ok = !(xtal_sync && mode_reg[CLK_OFF_BIT]);
    assign op_finish = CONV_DONE_I && !wr_event
                       && (state_reg == ST_SINGLE || state_reg == ST_CAL);

    // the mode register itself; a write always beats the auto-clear
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            mode_reg <= MODE_REG_RESET;
            arg_reg  <= 2'h0;
        end
        else if (wr_event)
        begin
            mode_reg <= wr_data_hold;
            arg_reg  <= wr_arg_hold;
        end
        else if (op_finish)
            mode_reg[OP_MODE_MSB:OP_MODE_LSB] <= OP_IDLE;
    end

    // mirror the register to the link side by toggle and echo
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            ack_meta        <= 1'b0;
            ack_sync        <= 1'b0;
            mirror_tgl_reg  <= 1'b0;
            mirror_data_reg <= MODE_REG_RESET;
        end
        else
        begin
            ack_meta <= mir_seen;
            ack_sync <= ack_meta;
            if (mirror_tgl_reg == ack_sync && mode_reg != mirror_data_reg)
            begin
                mirror_data_reg <= mode_reg;
                mirror_tgl_reg  <= ~mirror_tgl_reg;
            end
        end
    end

    // next enabled channel after cur, wrapping; stays put if none enabled
    function automatic logic [CH_W-1:0] next_channel(
        input logic [CH_W-1:0]         cur,
        input logic [NUM_CHANNELS-1:0] en
    );
        logic [CH_W-1:0] pick;
        logic            found;
        int              idx;
        pick  = cur;
        found = 1'b0;
        for (int i = 1; i <= NUM_CHANNELS; i++)
        begin
            idx = (int'(cur) + i) % NUM_CHANNELS;
            if (!found && en[idx])
            begin
                pick  = CH_W'(idx);
                found = 1'b1;
            end
        end
        return pick;
    endfunction : next_channel

    // state chosen by a freshly written mode field
    always_comb
    begin
        case (wr_data_hold[OP_MODE_MSB:OP_MODE_LSB])
            OP_IDLE:      state_next = ST_IDLE;
            OP_CONT_CONV: state_next = ST_CONT;
            OP_SINGLE:    state_next = ST_SINGLE;
            OP_STANDBY:   state_next = ST_STANDBY;
            default:      state_next = ST_CAL;
        endcase
    end

    // sequencer: a write abandons whatever runs and starts at once
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            state_reg         <= ST_IDLE;
            start_pending_reg <= 1'b0;
            channel_reg       <= '0;
        end
        else if (wr_event)
        begin
            state_reg         <= state_next;
            start_pending_reg <= (state_next == ST_CONT
                                  || state_next == ST_SINGLE
                                  || state_next == ST_CAL);
            channel_reg       <= CH_W'(wr_arg_hold);
        end
        else
        begin
            case (state_reg)
                ST_CONT:
                begin
                    if (CONV_DONE_I)
                    begin
                        channel_reg <= next_channel(channel_reg,
                                                    CHANNEL_ENABLE_I);
                        start_pending_reg <= 1'b1;
                    end
                    else if (run_ok)
                        start_pending_reg <= 1'b0;
                end
                ST_SINGLE, ST_CAL:
                begin
                    if (CONV_DONE_I)
                        state_reg <= ST_IDLE;
                    else if (run_ok)
                        start_pending_reg <= 1'b0;
                end
                ST_IDLE, ST_STANDBY:
                    start_pending_reg <= 1'b0;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // converter command outputs
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            CONV_START_O      <= 1'b0;
            CONV_ABORT_O      <= 1'b0;
            CONV_OP_O         <= OP_IDLE;
            CONV_CHANNEL_O    <= '0;
            CAL_TIME_SEL_O    <= 2'h0;
            STANDBY_O         <= 1'b0;
            CONVERSION_HALT_O <= 1'b0;
        end
        else
        begin
            CONV_START_O      <= start_pending_reg && run_ok && !wr_event
                                 && !CONV_DONE_I;
            CONV_ABORT_O      <= wr_event;
            CONV_OP_O         <= mode_reg[OP_MODE_MSB:OP_MODE_LSB];
            CONV_CHANNEL_O    <= channel_reg;
            CAL_TIME_SEL_O    <= arg_reg;
            STANDBY_O         <= (state_reg == ST_STANDBY);
            CONVERSION_HALT_O <= !run_ok;
        end
    end

    // status bits and ready pin; a write clears, a finished job sets
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            status_reg <= '0;
            READY_N_O  <= READY_N_RESET;
        end
        else if (wr_event)
        begin
            status_reg <= '0;
            READY_N_O  <= 1'b1;
        end
        else if (CONV_DONE_I && state_reg == ST_CAL)
        begin
            status_reg <= '1;
            READY_N_O  <= 1'b0;
        end
        else if (CONV_DONE_I
                 && (state_reg == ST_SINGLE || state_reg == ST_CONT))
        begin
            status_reg[channel_reg] <= 1'b1;
            READY_N_O  <= 1'b0;
        end
    end
    assign ADC_STATUS_O = status_reg;

    // result formatting: width and clamp
    logic [SAMPLE_WIDTH-1:0] formatted;
    always_comb
    begin
        if (mode_reg[WIDE_DATA_BIT])
            formatted = SAMPLE_I;
        else
            formatted = {8'h00, SAMPLE_I[SAMPLE_WIDTH-1 -: SHORT_WIDTH]};
        if (mode_reg[CLAMP_BIT] && OVER_RANGE_I)
            formatted = mode_reg[WIDE_DATA_BIT] ? 24'hffffff : 24'h00ffff;
        else if (mode_reg[CLAMP_BIT] && UNDER_RANGE_I)
            formatted = 24'h000000;
    end

    // channel data register update
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            CHAN_DATA_O       <= '0;
            CHAN_DATA_CH_O    <= '0;
            CHAN_DATA_VALID_O <= 1'b0;
        end
        else
        begin
            CHAN_DATA_VALID_O <= 1'b0;
            if (CONV_DONE_I && !wr_event
                && (state_reg == ST_SINGLE || state_reg == ST_CONT))
            begin
                CHAN_DATA_O       <= formatted;
                CHAN_DATA_CH_O    <= channel_reg;
                CHAN_DATA_VALID_O <= 1'b1;
            end
        end
    end

    // read formatting flags and master clock pin
    logic mclk_div;
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            CHAIN_READ_O                 <= 1'b0;
            CONT_READ_O                  <= 1'b0;
            WIDE_DATA_O                  <= 1'b0;
            mclk_div                     <= 1'b0;
            MASTER_CLOCK_OUTPUT_PIN_OE_O <= 1'b1;
        end
        else
        begin
            CHAIN_READ_O <= mode_reg[CHAIN_READ_BIT]
                            || mode_reg[CONT_READ_BIT];
            CONT_READ_O  <= mode_reg[CONT_READ_BIT];
            WIDE_DATA_O  <= mode_reg[WIDE_DATA_BIT];
            mclk_div     <= ~mclk_div;
            MASTER_CLOCK_OUTPUT_PIN_OE_O <= !mode_reg[CLK_OFF_BIT];
        end
    end
    assign MASTER_CLOCK_OUTPUT_PIN_O = mclk_div
                                       && MASTER_CLOCK_OUTPUT_PIN_OE_O;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    sequence single_done_s;
        state_reg == ST_SINGLE && CONV_DONE_I && !wr_event;
    endsequence
    sequence back_idle_s;
        READY_N_O == 1'b0 && mode_reg[OP_MODE_MSB:OP_MODE_LSB] == OP_IDLE
        && state_reg == ST_IDLE;
    endsequence

    wr_clears_a: assert property (wr_event
                                 |=> READY_N_O && status_reg == '0
                                 && CONV_ABORT_O)
        else $error("write did not clear status and ready");
    wr_loads_a: assert property (wr_event
                                 |=> mode_reg == $past(wr_data_hold)
                                 && arg_reg == $past(wr_arg_hold))
        else $error("mode write not loaded");
    mode_jump_a: assert property (wr_event
                                  |=> state_reg == $past(state_next))
        else $error("new mode not entered at once");
    single_end_a: assert property (single_done_s |=> back_idle_s)
        else $error("single conversion did not return to idle");
    cont_next_a: assert property (state_reg == ST_CONT && CONV_DONE_I
                                  && !wr_event && run_ok
                                  |=> start_pending_reg ##1 CONV_START_O)
        else $error("continuous mode did not restart");
    clk_off_a: assert property (mode_reg[CLK_OFF_BIT]
                                |=> !MASTER_CLOCK_OUTPUT_PIN_OE_O)
        else $error("clock output not floated");
    xtal_halt_a: assert property (!run_ok [*2] |-> !CONV_START_O)
        else $error("conversion started while clock halted");
    chain_a: assert property (mode_reg[CONT_READ_BIT]
                              |=> CHAIN_READ_O)
        else $error("continuous read without chaining");
    narrow_a: assert property (CHAN_DATA_VALID_O && !WIDE_DATA_O
                               && $stable(mode_reg[WIDE_DATA_BIT])
                               |-> CHAN_DATA_O[23:16] == 8'h00)
        else $error("16-bit data has upper bits set");
    clamp_a: assert property (mode_reg[CLAMP_BIT] && UNDER_RANGE_I
                              && !OVER_RANGE_I && !wr_event && CONV_DONE_I
                              && state_reg == ST_SINGLE
                              |=> CHAN_DATA_O == '0)
        else $error("under-range data not clamped to zero");

endmodule : adc_mode_control

// ===== host_link_model.sv
// host_link_model: host side of the register link, clock only in frames.
// assumes: the device samples strobes on the rising link clock edge.
`timescale 1ns/100ps
module host_link_model (
    // link port toward the device
    output logic            link_clk_o,
    output logic            link_wr_o,
    output logic            link_rd_o,
    output logic      [7:0] link_addr_o,
    output logic      [7:0] link_wdata_o,
    // read return
    input  wire logic [7:0] link_rdata_i
);
    // lines at rest: clock parked low, strobes off
    initial
    begin
        link_clk_o = 1'b0;
        link_wr_o = 1'b0;
        link_rd_o = 1'b0;
        link_addr_o = 8'h00;
        link_wdata_o = 8'h00;
    end

    // n link clock periods of 125 ns
    task automatic idle(input int n);
        repeat (n)
        begin
            #62.5 link_clk_o = 1'b1;
            #62.5 link_clk_o = 1'b0;
        end
    endtask : idle

    // one write frame; address bits 1..0 travel as the argument
    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        idle(1); // lets the previous frame's release settle first
        link_addr_o = a;
        link_wdata_o = v;
        link_wr_o = 1'b1;
        idle(1);
        link_wr_o = 1'b0;
        link_addr_o = ~a; // released lines show no stale value
        link_wdata_o = ~v;
    endtask : write_reg

    // read frame; eight idle edges let two queued mirror updates land
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        idle(8);
        link_addr_o = a;
        link_rd_o = 1'b1;
        idle(1);
        v = link_rdata_i;
        link_rd_o = 1'b0;
        link_addr_o = ~a;
    endtask : read_reg
endmodule : host_link_model

// ===== adc_mode_control_test.sv
// adc_mode_control_test: mode register and sequencer tests.
// assumes: host_link_model drives the link; the converter is driven here.
`timescale 1ns/100ps
module adc_mode_control_test;
    import adc_mode_pkg::*;
    logic        clk_sys, resetn, link_clk, link_wr, link_rd, crystal;
    logic [7:0]  link_addr, link_wdata, link_rdata, rd_val, d, chan_en;
    logic        mclk_o, mclk_oe, conv_start, conv_abort, conv_done;
    logic        over_r, under_r, standby, halt, data_valid, ready_n;
    logic        chain, cont, wide;
    logic [23:0] sample, chan_data;
    logic [2:0]  conv_op, conv_ch, data_ch;
    logic [1:0]  cal_sel;
    logic [7:0]  status;
    int          fails, checked;

    adc_mode_control u_adc_mode_control (
        .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .LINK_CLK_I(link_clk),
        .LINK_WR_I(link_wr), .LINK_RD_I(link_rd), .LINK_ADDR_I(link_addr),
        .LINK_WDATA_I(link_wdata), .LINK_RDATA_O(link_rdata),
        .CRYSTAL_MODE_I(crystal), .MASTER_CLOCK_OUTPUT_PIN_O(mclk_o),
        .MASTER_CLOCK_OUTPUT_PIN_OE_O(mclk_oe), .CHANNEL_ENABLE_I(chan_en),
        .CONV_DONE_I(conv_done), .SAMPLE_I(sample), .OVER_RANGE_I(over_r),
        .UNDER_RANGE_I(under_r), .CONV_START_O(conv_start),
        .CONV_ABORT_O(conv_abort), .CONV_OP_O(conv_op),
        .CONV_CHANNEL_O(conv_ch), .CAL_TIME_SEL_O(cal_sel),
        .STANDBY_O(standby), .CONVERSION_HALT_O(halt),
        .CHAN_DATA_O(chan_data), .CHAN_DATA_CH_O(data_ch),
        .CHAN_DATA_VALID_O(data_valid), .ADC_STATUS_O(status),
        .READY_N_O(ready_n), .CHAIN_READ_O(chain), .CONT_READ_O(cont),
        .WIDE_DATA_O(wide));

    host_link_model u_host_link_model (
        .link_clk_o(link_clk), .link_wr_o(link_wr), .link_rd_o(link_rd),
        .link_addr_o(link_addr), .link_wdata_o(link_wdata),
        .link_rdata_i(link_rdata));

    // system clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // compare one value and count it
    task automatic check(input string what, input logic [23:0] got,
                         input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_sys(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_sys

    // converter reports one result for a single cycle
    task automatic finish_conv(input logic [23:0] s, input logic ov,
                               input logic un);
        @(negedge clk_sys);
        conv_done = 1'b1;
        sample = s;
        over_r = ov;
        under_r = un;
        @(negedge clk_sys);
        conv_done = 1'b0;
    endtask : finish_conv

    // bounded wait for the next conversion start
    task automatic wait_start;
        int n;
        n = 0;
        while (conv_start !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("start", conv_start, 1'b1);
    endtask : wait_start

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // watchdog: tests need well under 100 us
    initial
    begin
        #500000;
        fails++;
        test_done();
    end

    // main sequence
    initial
    begin
        {resetn, crystal, conv_done, over_r, under_r} = 5'h00;
        fails = 0;
        checked = 0;
        chan_en = 8'h05;
        sample = 24'h000000;
        wait_sys(12);
        resetn = 1'b1;
        check("ready pin", ready_n, 1'b1);
        check("clock oe", mclk_oe, 1'b1);
        u_host_link_model.read_reg(8'h38, rd_val);
        check("mode reset", rd_val, MODE_REG_RESET);
        $display("test reset done");
        // single conversion on channel 2, 16-bit, clamped
        u_host_link_model.write_reg(8'h3a, 8'h41);
        wait_sys(10);
        check("op", conv_op, OP_SINGLE);
        check("channel", conv_ch, 3'h2);
        finish_conv(24'h7fffff, 1'b1, 1'b0);
        check("valid", data_valid, 1'b1);
        check("clamp data", chan_data, 24'h00ffff);
        check("ready", ready_n, 1'b0);
        check("status", status, 8'h04);
        check("data ch", data_ch, 3'h2);
        u_host_link_model.read_reg(8'h38, rd_val);
        check("auto idle", rd_val, 8'h01);
        $display("test single done");
        // single conversion on channel 0, 24-bit, clamped under range
        u_host_link_model.write_reg(8'h38, 8'h43);
        wait_sys(10);
        finish_conv(24'h123456, 1'b0, 1'b1);
        check("clamp low", chan_data, 24'h000000);
        check("data ch 0", data_ch, 3'h0);
        check("wide flag", wide, 1'b1);
        $display("test clamp done");
        // every mode code and every address of the window
        for (int i = 0; i < 8; i++)
        begin
            d = {i[2:0], i[0], i[1], i[2], ~i[0], 1'b0};
            u_host_link_model.write_reg(8'h38 + 8'(i), d);
            wait_sys(10);
            check("mode", conv_op, i[2:0]);
            check("arg", cal_sel, i[1:0]);
            check("standby", standby, i == 3);
            check("ready hi", ready_n, 1'b1);
            check("status clr", status, 8'h00);
            check("clock oe", mclk_oe, !d[4]);
            check("chain", chain, d[3] | d[2]);
            check("cont", cont, d[2]);
            check("wide", wide, d[1]);
        end
        u_host_link_model.write_reg(8'h37, 8'h20);
        wait_sys(10);
        check("ignored", conv_op, OP_SYS_FULL);
        u_host_link_model.read_reg(8'h38, rd_val);
        check("readback", rd_val, 8'hfc);
        $display("test modes done");
        // crystal clocking with clock output off halts conversions
        wait_sys(1);
        crystal = 1'b1;
        u_host_link_model.write_reg(8'h38, 8'h10);
        wait_sys(10);
        check("halt", halt, 1'b1);
        check("floated", mclk_oe, 1'b0);
        check("clock out", mclk_o, 1'b0);
        u_host_link_model.read_reg(8'h38, rd_val);
        check("link alive", rd_val, 8'h10);
        wait_sys(1);
        crystal = 1'b0;
        wait_sys(4);
        check("no halt", halt, 1'b0);
        $display("test clock done");
        // continuous, 24-bit, channels 0 and 2 enabled
        u_host_link_model.write_reg(8'h38, 8'h22);
        wait_sys(10);
        check("first ch", conv_ch, 3'h0);
        finish_conv(24'h123456, 1'b0, 1'b0);
        check("wide data", chan_data, 24'h123456);
        check("status 0", status, 8'h01);
        wait_start();
        check("next ch", conv_ch, 3'h2);
        finish_conv(24'h800000, 1'b0, 1'b1);
        check("unclamped", chan_data, 24'h800000);
        check("status 2", status, 8'h05);
        wait_start();
        check("wrap ch", conv_ch, 3'h0);
        $display("test continuous done");
        test_done();
    end
endmodule : adc_mode_control_test
